// file: include/isz_pkg.sv
package isz_pkg;
  localparam int ISZ_ADDR_W = 14;
  localparam int ISZ_BANK_W = 6;
  localparam int ISZ_OPC_HI = 15;
  localparam int ISZ_OPC_LO = 10;
  localparam logic [5:0] ISZ_OPC_MATCH = 6'h0f;
  localparam int ISZ_DST_BIT = 9;
  localparam int ISZ_BANK_BIT = 8;
  localparam logic [7:0] ISZ_IDX_LIMIT = 8'h5f;
  localparam logic [7:0] ISZ_ACC_SPLIT = 8'h60;
  localparam logic [5:0] ISZ_ACC_HI_BANK = 6'h3f;
  localparam logic [5:0] ISZ_ACC_LO_BANK = 6'h00;
  localparam logic [1:0] ISZ_LAST_Q = 2'h3;
  localparam logic [1:0] ISZ_MIN_WORDS = 2'h1;
  localparam logic [1:0] ISZ_RST_WORDS = 2'h1;
  localparam logic [7:0] ISZ_RST_BYTE = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE,
    S_DEC,
    S_READ,
    S_PROC,
    S_WRITE,
    S_FILL
  } isz_state_t;
endpackage

// file: include/isz_addr_if.sv
`timescale 1ns/1ps
interface isz_addr_if;
  import isz_pkg::*;
  logic [7:0] f;
  logic bank;
  logic ext_en;
  logic [ISZ_BANK_W-1:0] bank_hi;
  logic [ISZ_ADDR_W-1:0] idx_base;
  logic [ISZ_ADDR_W-1:0] addr;
  logic indexed;
  modport calc (input f, bank, ext_en, bank_hi, idx_base, output addr, indexed);
  modport user (output f, bank, ext_en, bank_hi, idx_base, input addr, indexed);
endinterface

// file: rtl/isz_addr_calc.sv
`timescale 1ns/1ps
module isz_addr_calc (
  isz_addr_if.calc a
);
  import isz_pkg::*;

  always_comb begin
    a.indexed = 1'b0;
    if (a.bank) begin
      a.addr = {a.bank_hi, a.f};
    end else if (a.ext_en && (a.f <= ISZ_IDX_LIMIT)) begin
      a.indexed = 1'b1;
      a.addr = a.idx_base + {{(ISZ_ADDR_W-8){1'b0}}, a.f};
    end else if (a.f < ISZ_ACC_SPLIT) begin
      a.addr = {ISZ_ACC_LO_BANK, a.f};
    end else begin
      a.addr = {ISZ_ACC_HI_BANK, a.f};
    end
  end
endmodule

// file: rtl/isz_exec.sv
`timescale 1ns/1ps
module isz_exec (
  input wire logic clock,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [15:0] opcode,
  input wire logic [1:0] next_words,
  input wire logic ext_set_en,
  input wire logic [isz_pkg::ISZ_BANK_W-1:0] bank_select_register,
  input wire logic [isz_pkg::ISZ_ADDR_W-1:0] index_base,
  output logic [isz_pkg::ISZ_ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  output logic w_wr,
  output logic [7:0] w_wdata,
  output logic status_wr,
  output logic first_quarter_phase,
  output logic fourth_quarter_phase,
  output logic no_operation_cycle,
  output logic busy,
  output logic done
);
  import isz_pkg::*;

  typedef struct packed {
    isz_state_t st;
    logic [1:0] qtr;
    logic [1:0] left;
    logic [1:0] words;
    logic dst;
    logic bank;
    logic ext;
    logic [7:0] f;
    logic [ISZ_BANK_W-1:0] bank_hi;
    logic [ISZ_ADDR_W-1:0] idx;
    logic [ISZ_ADDR_W-1:0] addr;
    logic [7:0] res;
  } isz_regs_t;

  localparam isz_regs_t ISZ_REGS_RST = '{
    st: S_IDLE, qtr: 2'h0, left: 2'h0, words: ISZ_RST_WORDS, dst: 1'b0, bank: 1'b0,
    ext: 1'b0, f: ISZ_RST_BYTE, bank_hi: '0, idx: '0, addr: '0, res: ISZ_RST_BYTE};

  isz_regs_t r_q;
  isz_regs_t r_d;

  isz_addr_if aif ();

  function automatic logic isz_is_op(input logic [15:0] op);
    return op[ISZ_OPC_HI:ISZ_OPC_LO] == ISZ_OPC_MATCH;
  endfunction

  assign aif.f = r_q.f;
  assign aif.bank = r_q.bank;
  assign aif.ext_en = r_q.ext;
  assign aif.bank_hi = r_q.bank_hi;
  assign aif.idx_base = r_q.idx;

  isz_addr_calc u_calc (
    .a(aif.calc)
  );

  always_comb begin
    r_d = r_q;
    case (r_q.st)
      S_IDLE: begin
        if (instr_valid && isz_is_op(opcode)) begin
          r_d.dst = opcode[ISZ_DST_BIT];
          r_d.bank = opcode[ISZ_BANK_BIT];
          r_d.f = opcode[7:0];
          r_d.ext = ext_set_en;
          r_d.bank_hi = bank_select_register;
          r_d.idx = index_base;
          r_d.words = (next_words < ISZ_MIN_WORDS) ? ISZ_MIN_WORDS : next_words;
          r_d.st = S_DEC;
        end
      end
      S_DEC: begin
        r_d.addr = aif.addr;
        r_d.st = S_READ;
      end
      S_READ: begin
        r_d.res = mem_rdata;
        r_d.st = S_PROC;
      end
      S_PROC: begin
        r_d.res = r_q.res + 8'h01;
        r_d.st = S_WRITE;
      end
      S_WRITE: begin
        if (r_q.res == ISZ_RST_BYTE) begin
          r_d.st = S_FILL;
          r_d.qtr = 2'h0;
          r_d.left = r_q.words;
        end else begin
          r_d.st = S_IDLE;
        end
      end
      S_FILL: begin
        r_d.qtr = r_q.qtr + 2'h1;
        if (r_q.qtr == ISZ_LAST_Q) begin
          r_d.left = r_q.left - 2'h1;
          if (r_q.left == 2'h1) begin
            r_d.st = S_IDLE;
          end
        end
      end
      default: begin
        r_d = ISZ_REGS_RST;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r_q <= ISZ_REGS_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign mem_addr = r_q.addr;
  assign mem_rd = (r_q.st == S_READ);
  assign mem_wr = (r_q.st == S_WRITE) && r_q.dst;
  assign w_wr = (r_q.st == S_WRITE) && !r_q.dst;
  assign mem_wdata = r_q.res;
  assign w_wdata = r_q.res;
  assign status_wr = 1'b0;
  assign first_quarter_phase = (r_q.st == S_DEC) || ((r_q.st == S_FILL) && (r_q.qtr == 2'h0));
  assign fourth_quarter_phase = (r_q.st == S_WRITE) ||
    ((r_q.st == S_FILL) && (r_q.qtr == ISZ_LAST_Q));
  assign no_operation_cycle = (r_q.st == S_FILL);
  assign busy = (r_q.st != S_IDLE);
  assign done = ((r_q.st == S_WRITE) && (r_q.res != ISZ_RST_BYTE)) ||
    ((r_q.st == S_FILL) && (r_q.qtr == ISZ_LAST_Q) && (r_q.left == 2'h1));

  property p_accept;
    @(posedge clock) disable iff (!rstn)
      (!busy && instr_valid && isz_is_op(opcode)) |=> first_quarter_phase && busy;
  endproperty
  a_accept: assert property (p_accept) else $error("opcode not taken");

  property p_quarters;
    @(posedge clock) disable iff (!rstn)
      (r_q.st == S_DEC) |-> ##1 mem_rd ##1 (!mem_rd && !mem_wr && !w_wr) ##1 fourth_quarter_phase;
  endproperty
  a_quarters: assert property (p_quarters) else $error("quarter order wrong");

  property p_mem_sum;
    @(posedge clock) disable iff (!rstn)
      mem_wr |-> (mem_wdata == 8'($past(mem_rdata, 2) + 8'h01)) && $past(mem_rd, 2);
  endproperty
  a_mem_sum: assert property (p_mem_sum) else $error("memory write not operand plus one");

  property p_w_sum;
    @(posedge clock) disable iff (!rstn)
      w_wr |-> (w_wdata == 8'($past(mem_rdata, 2) + 8'h01)) && $past(mem_rd, 2);
  endproperty
  a_w_sum: assert property (p_w_sum) else $error("w write not operand plus one");

  property p_skip;
    @(posedge clock) disable iff (!rstn)
      ((mem_wr || w_wr) && (mem_wdata == 8'h00)) |=> no_operation_cycle[*4];
  endproperty
  a_skip: assert property (p_skip) else $error("zero result did not skip");

  property p_no_skip;
    @(posedge clock) disable iff (!rstn)
      ((mem_wr || w_wr) && (mem_wdata != 8'h00)) |-> done ##1 !busy;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("nonzero result skipped");

  property p_skip_two;
    @(posedge clock) disable iff (!rstn)
      ((mem_wr || w_wr) && (mem_wdata == 8'h00) && (r_q.words == 2'h2))
        |=> no_operation_cycle[*8] ##1 !busy;
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two word skip length wrong");

  property p_nop_quiet;
    @(posedge clock) disable iff (!rstn)
      no_operation_cycle |-> !mem_rd && !mem_wr && !w_wr && !status_wr;
  endproperty
  a_nop_quiet: assert property (p_nop_quiet) else $error("activity in inserted cycle");

  property p_bank_addr;
    @(posedge clock) disable iff (!rstn)
      (mem_rd && r_q.bank) |-> (mem_addr == {r_q.bank_hi, r_q.f});
  endproperty
  a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");

  property p_idx_addr;
    @(posedge clock) disable iff (!rstn)
      (mem_rd && !r_q.bank && r_q.ext && (r_q.f <= ISZ_IDX_LIMIT))
        |-> aif.indexed && (mem_addr == ISZ_ADDR_W'(r_q.idx + r_q.f));
  endproperty
  a_idx_addr: assert property (p_idx_addr) else $error("indexed address wrong");

  property p_status;
    @(posedge clock) disable iff (!rstn)
      busy |-> !status_wr;
  endproperty
  a_status: assert property (p_status) else $error("status written");

  c_no_skip: cover property (@(posedge clock) disable iff (!rstn)
    (mem_wr || w_wr) && (mem_wdata != 8'h00));
  c_skip_one: cover property (@(posedge clock) disable iff (!rstn)
    (mem_wr || w_wr) && (mem_wdata == 8'h00) && (r_q.words == 2'h1));
  c_skip_three: cover property (@(posedge clock) disable iff (!rstn)
    (mem_wr || w_wr) && (mem_wdata == 8'h00) && (r_q.words == 2'h3));
  c_indexed: cover property (@(posedge clock) disable iff (!rstn)
    mem_rd && !r_q.bank && r_q.ext && (r_q.f <= ISZ_IDX_LIMIT));
endmodule

// file: test/test_increment_skip_if_zero_exec.sv
`timescale 1ns/1ps
module test_increment_skip_if_zero_exec;
  import isz_pkg::*;
  logic clock, rstn, instr_valid, ext_set_en;
  logic [15:0] opcode;
  logic [1:0] next_words;
  logic [ISZ_BANK_W-1:0] bank_select_register;
  logic [ISZ_ADDR_W-1:0] index_base, mem_addr;
  logic [7:0] mem_rdata, mem_wdata, w_wdata;
  logic mem_rd, mem_wr, w_wr, status_wr, first_quarter_phase, fourth_quarter_phase;
  logic no_operation_cycle, busy, done;
  int n_errors = 0;
  int num_checks = 0;

  isz_exec uut (
    .clock(clock), .rstn(rstn), .instr_valid(instr_valid), .opcode(opcode),
    .next_words(next_words), .ext_set_en(ext_set_en),
    .bank_select_register(bank_select_register), .index_base(index_base),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .w_wr(w_wr), .w_wdata(w_wdata), .status_wr(status_wr),
    .first_quarter_phase(first_quarter_phase), .fourth_quarter_phase(fourth_quarter_phase),
    .no_operation_cycle(no_operation_cycle), .busy(busy), .done(done)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task finish_test;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one instruction from presentation to done, judging every strobe on the way
  task run(input logic [15:0] opc, input logic [1:0] nw, input logic ext,
           input logic [5:0] bank_hi, input logic [13:0] base, input logic [7:0] rd,
           input logic [13:0] ea, input int ed);
    int i, rd_at, wr_at, n_fill, dn_at;
    logic sw;
    logic [7:0] sum;
    sum = rd + 8'h01;
    rd_at = 0; wr_at = 0; n_fill = 0; dn_at = 0; sw = 1'b0;
    @(negedge clock);
    chk(16'(busy), 16'h0);
    opcode = opc; next_words = nw; ext_set_en = ext;
    bank_select_register = bank_hi; index_base = base; mem_rdata = rd;
    instr_valid = 1'b1;
    for (i = 1; i <= 24 && dn_at == 0; i++) begin
      @(negedge clock);
      instr_valid = 1'b0;
      if (i == 1) chk(16'(first_quarter_phase), 16'h1);
      if (mem_rd === 1'b1) begin
        rd_at = i;
        chk(16'(mem_addr), 16'(ea));
      end
      if (mem_wr === 1'b1 || w_wr === 1'b1) begin
        wr_at = i;
        chk(16'(mem_wdata), 16'(sum));
        chk(16'(w_wdata), 16'(sum));
        chk(16'(mem_wr), 16'(opc[9]));
        chk(16'(w_wr), 16'(!opc[9]));
        chk(16'(fourth_quarter_phase), 16'h1);
      end
      // inserted cycles keep the four-quarter rhythm
      if (i >= 5) begin
        chk(16'(first_quarter_phase), 16'((i % 4) == 1));
        chk(16'(fourth_quarter_phase), 16'((i % 4) == 0));
      end
      if (no_operation_cycle === 1'b1) n_fill++;
      if (status_wr !== 1'b0) sw = 1'b1;
      if (done === 1'b1) dn_at = i;
    end
    chk(16'(rd_at), 16'h2);
    chk(16'(wr_at), 16'h4);
    chk(16'(n_fill), 16'(ed - 4));
    chk(16'(sw), 16'h0);
    chk(16'(dn_at), 16'(ed));
    if (dn_at == 0) finish_test();
  endtask

  task t_low_bank;
    run(16'h3e20, 2'h1, 1'b0, 6'h15, 14'h0000, 8'h41, 14'h0020, 4);
  endtask

  task t_high_bank_to_w;
    run(16'h3c80, 2'h1, 1'b0, 6'h00, 14'h0000, 8'h7e, 14'h3f80, 4);
  endtask

  task t_bank_wrap_skip;
    run(16'h3f10, 2'h1, 1'b1, 6'h05, 14'h0100, 8'hff, 14'h0510, 8);
  endtask

  task t_indexed_limit_two_words;
    run(16'h3e5f, 2'h2, 1'b1, 6'h05, 14'h0100, 8'hff, 14'h015f, 12);
  endtask

  task t_above_limit_three_words;
    run(16'h3c60, 2'h3, 1'b1, 6'h00, 14'h0100, 8'hff, 14'h3f60, 16);
  endtask

  task t_zero_words_wrap_index;
    run(16'h3e20, 2'h0, 1'b1, 6'h00, 14'h3ff0, 8'hff, 14'h0010, 8);
  endtask

  // a plain increment encoding must not start this unit
  task t_other_opcode;
    int i;
    @(negedge clock);
    opcode = 16'h2a20;
    instr_valid = 1'b1;
    for (i = 0; i < 4; i++) begin
      @(negedge clock);
      chk(16'(busy), 16'h0);
    end
    instr_valid = 1'b0;
  endtask

  initial begin
    rstn = 1'b0; instr_valid = 1'b0; opcode = 16'h0000; next_words = 2'h1;
    ext_set_en = 1'b0; bank_select_register = 6'h00; index_base = 14'h0000;
    mem_rdata = 8'h00;
    repeat (20) @(negedge clock);
    chk(16'(busy), 16'h0);
    rstn = 1'b1;
    t_low_bank();
    t_high_bank_to_w();
    t_bank_wrap_skip();
    t_indexed_limit_two_words();
    t_above_limit_three_words();
    t_zero_words_wrap_index();
    t_other_opcode();
    t_low_bank();
    finish_test();
  end
endmodule
